// ### pcie_rx_params.svh
// Offsets, field positions, reset values and timing counts
`ifndef PCIE_RX_PARAMS_SVH
`define PCIE_RX_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RX_CTRL_OFF 8'h00
`define RX_THRESH_OFF 8'h04
`define RX_STATUS_OFF 8'h08
`define RX_PEND_OFF 8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_ECRC_BIT 0
`define CTRL_PAIR_LSB 1
`define CTRL_RESET 32'h0000_0000
`define THRESH_HDR_LSB 0
`define THRESH_DATA_LSB 8
`define THRESH_RESET 32'h0000_2008
`define STAT_NPUR_BIT 0
`define STAT_PUR_BIT 1
`define STAT_MALF_BIT 2
`define STAT_UNSUP_BIT 3

// ----------------------------------------
// Header decode and timing
// ----------------------------------------
`define LOCKED_RD_32 8'h01
`define LOCKED_RD_64 8'h21
`define FMT_RSVD_BIT 7
`define CLK_PERIOD_NS 8
`define UPDFC_TIMER_NS 30000
`define UPDFC_TIMER_CYC ((`UPDFC_TIMER_NS) / (`CLK_PERIOD_NS))
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ### pcie_rx_pkg.sv
// Types shared by the receive packet interface
package pcie_rx_pkg;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_BUSY = 2'b10
  } rx_state_e;
  typedef logic [7:0] credit_t;
endpackage

// ### credit_return_tracker.sv
// Per credit type accumulator that raises a flow-control update request
`timescale 1ns/1ps
`default_nettype none
module credit_return_tracker
  import pcie_rx_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic returnStrobe,
  input wire credit_t returnAmount,
  input wire logic bufferFull,
  input wire logic timerTick,
  input wire credit_t threshold,
  input wire logic updateTaken,
  output logic [CNT_W-1:0] pending,
  output logic updateRequest
);
  logic [CNT_W-1:0] addend;
  logic [CNT_W-1:0] next_pending;
  logic timerDue;

  assign addend = returnStrobe ? CNT_W'(returnAmount) : '0;

  always_comb begin
    if (updateTaken) begin
      next_pending = addend;
    end else begin
      next_pending = pending + addend;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  // Timer expiry held until the update goes out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timerDue <= 1'b0;
    end else if (timerTick && (next_pending != '0)) begin
      timerDue <= 1'b1;
    end else if (updateTaken) begin
      timerDue <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      updateRequest <= 1'b0;
    end else begin
      updateRequest <= bufferFull || timerDue ||
        ((next_pending != '0) &&
         (next_pending >= CNT_W'(threshold)));
    end
  end
endmodule
`default_nettype wire

// ### pcie_rx_tlp_interface.sv
// Receive packet interface: delivery, flags, address match, credits
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`include "pcie_rx_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pcie_rx_tlp_interface
  import pcie_rx_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter bit ECRC_EN = 1'b1,
  parameter int CNT_W = 12,
  parameter int UPDFC_CYCLES = `UPDFC_TIMER_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] linkWord,
  input wire logic linkValid,
  input wire logic linkFirst,
  input wire logic linkLast,
  input wire logic linkUpperHalfOnly,
  input wire logic linkCrcBad,
  input wire logic linkLengthBad,
  input wire logic [6:0] linkBarHit,
  output logic [DATA_W-1:0] recv_pkt_word,
  output logic recv_pkt_valid,
  output logic recv_pkt_first,
  output logic recv_pkt_last,
  output logic recv_upper_half_only,
  output logic recv_e2e_crc_fail,
  output logic recv_unsupported_flag,
  output logic recv_malformed_flag,
  output logic [6:0] recv_bar_hit,
  input wire logic user_nonposted_unsupported,
  input wire logic user_posted_unsupported,
  input wire logic [3:0] user_buffer_full,
  input wire logic [1:0] header_credit_returned,
  input wire logic [1:0] data_credit_returned,
  input wire logic [15:0] data_credit_count,
  output logic [3:0] updateFcRequest,
  input wire logic [3:0] updateFcTaken
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [31:0] ctrlReg;
  logic [31:0] threshReg;
  logic [3:0] statusReg;
  logic [3:0] next_status;
  logic [3:0] statusSet;
  logic [3:0] statusClear;
  logic [CNT_W-1:0] pendArr [4];

  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic [31:0] readValue;
  logic readHit;

  // ----------------------------------------
  // Bus slave: write path
  // ----------------------------------------
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (s_axi_awvalid && !awHeld) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && !wHeld) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr[7:2] == `RX_CTRL_OFF >> 2) begin
        s_axi_bresp <= `AXI_OKAY;
      end else if (awAddr[7:2] == `RX_THRESH_OFF >> 2) begin
        s_axi_bresp <= `AXI_OKAY;
      end else if (awAddr[7:2] == `RX_STATUS_OFF >> 2) begin
        s_axi_bresp <= `AXI_OKAY;
      end else begin
        s_axi_bresp <= `AXI_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control byte: check enable and 64-bit pair flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrlReg <= `CTRL_RESET;
    end else if (doWrite && awAddr[7:2] == `RX_CTRL_OFF >> 2 &&
                 wStrb[0]) begin
      ctrlReg <= {24'h00_0000, 4'h0, wData[3:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      threshReg <= `THRESH_RESET;
    end else if (doWrite && awAddr[7:2] == `RX_THRESH_OFF >> 2) begin
      if (wStrb[0]) begin
        threshReg[7:0] <= wData[7:0];
      end
      if (wStrb[1]) begin
        threshReg[15:8] <= wData[15:8];
      end
    end
  end

  // ----------------------------------------
  // Sticky status, write one to clear
  // ----------------------------------------
  assign statusClear = (doWrite && wStrb[0] &&
    awAddr[7:2] == `RX_STATUS_OFF >> 2) ? wData[3:0] : 4'h0;

  always_comb begin
    statusSet = 4'h0;
    statusSet[`STAT_NPUR_BIT] = user_nonposted_unsupported;
    statusSet[`STAT_PUR_BIT] = user_posted_unsupported;
    statusSet[`STAT_MALF_BIT] = recv_malformed_flag;
    statusSet[`STAT_UNSUP_BIT] = recv_unsupported_flag;
    next_status = (statusReg & ~statusClear) | statusSet;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      statusReg <= 4'h0;
    end else begin
      statusReg <= next_status;
    end
  end

  // ----------------------------------------
  // Bus slave: read path
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    readHit = 1'b1;
    readValue = 32'h0000_0000;
    if (s_axi_araddr[7:2] == `RX_CTRL_OFF >> 2) begin
      readValue = ctrlReg;
    end else if (s_axi_araddr[7:2] == `RX_THRESH_OFF >> 2) begin
      readValue = {16'h0000, threshReg[15:0]};
    end else if (s_axi_araddr[7:2] == `RX_STATUS_OFF >> 2) begin
      readValue = {28'h000_0000, statusReg};
    end else if (s_axi_araddr[7:4] == `RX_PEND_OFF >> 4) begin
      readValue = 32'(pendArr[s_axi_araddr[3:2]]);
    end else begin
      readHit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readValue;
      s_axi_rresp <= readHit ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Packet delivery
  // ----------------------------------------
  rx_state_e rxState;
  logic [DATA_W-1:0] orderedWord;
  logic [7:0] firstByte;
  logic lockedRead;
  logic formatBad;
  logic [6:0] foldedHit;
  logic beatTaken;

  // Inbound stream holds byte 0 in the low lane
  always_comb begin
    for (int i = 0; i < DATA_W / 8; i++) begin
      orderedWord[DATA_W-1-8*i -: 8] = linkWord[8*i +: 8];
    end
  end

  assign firstByte = orderedWord[DATA_W-1 -: 8];
  assign lockedRead = (firstByte == `LOCKED_RD_32) ||
                      (firstByte == `LOCKED_RD_64);
  assign formatBad = firstByte[`FMT_RSVD_BIT];
  // A beat outside a packet without a start is dropped
  assign beatTaken = linkValid && (linkFirst || rxState == RX_BUSY);

  always_comb begin
    foldedHit = linkBarHit;
    for (int p = 0; p < 3; p++) begin
      if (ctrlReg[`CTRL_PAIR_LSB + p]) begin
        foldedHit[2*p] = linkBarHit[2*p] | linkBarHit[2*p+1];
        foldedHit[2*p+1] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState <= RX_IDLE;
    end else begin
      case (rxState)
        RX_IDLE: begin
          if (linkValid && linkFirst && !linkLast) begin
            rxState <= RX_BUSY;
          end
        end
        RX_BUSY: begin
          if (linkValid && linkLast) begin
            rxState <= RX_IDLE;
          end
        end
        default: begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recv_pkt_word <= '0;
      recv_pkt_valid <= 1'b0;
      recv_pkt_first <= 1'b0;
      recv_pkt_last <= 1'b0;
      recv_upper_half_only <= 1'b0;
    end else begin
      recv_pkt_valid <= beatTaken;
      recv_pkt_first <= linkValid && linkFirst;
      recv_pkt_last <= beatTaken && linkLast;
      recv_upper_half_only <= (DATA_W == 64) && beatTaken &&
                              linkUpperHalfOnly;
      if (beatTaken) begin
        recv_pkt_word <= orderedWord;
      end
    end
  end

  // Match vector moves only with a start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recv_bar_hit <= 7'h00;
    end else if (linkValid && linkFirst) begin
      recv_bar_hit <= foldedHit;
    end
  end

  // Packet flags stand from start through end, or until two idle cycles clear them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recv_unsupported_flag <= 1'b0;
      recv_malformed_flag <= 1'b0;
    end else if (linkValid && linkFirst) begin
      recv_unsupported_flag <= lockedRead;
      recv_malformed_flag <= formatBad || linkLengthBad ||
                             rxState == RX_BUSY;
    end else if (beatTaken) begin
      recv_malformed_flag <= recv_malformed_flag || linkLengthBad;
    end else if (recv_pkt_last || !recv_pkt_valid) begin
      recv_unsupported_flag <= 1'b0;
      recv_malformed_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recv_e2e_crc_fail <= 1'b0;
    end else begin
      recv_e2e_crc_fail <= ECRC_EN && ctrlReg[`CTRL_ECRC_BIT] &&
        beatTaken && linkLast && linkCrcBad;
    end
  end

  // ----------------------------------------
  // Flow-control credit return
  // ----------------------------------------
  logic [$clog2(UPDFC_CYCLES+1)-1:0] timerCount;
  logic timerTick;

  assign timerTick = (timerCount == '0);

  always_ff @(posedge clk) begin
    if (sys_rst || timerTick) begin
      timerCount <= ($clog2(UPDFC_CYCLES+1))'(UPDFC_CYCLES - 1);
    end else begin
      timerCount <= timerCount - 1'b1;
    end
  end

  // Order: posted hdr, non-posted hdr, posted data, non-posted data
  for (genvar g = 0; g < 4; g++) begin : g_credit
    logic strobe;
    credit_t amount;
    credit_t limit;
    if (g < 2) begin : g_hdr
      assign strobe = header_credit_returned[g];
      assign amount = 8'h01;
      assign limit = threshReg[`THRESH_HDR_LSB +: 8];
    end else begin : g_data
      assign strobe = data_credit_returned[g-2];
      assign amount = data_credit_count[8*(g-2) +: 8];
      assign limit = threshReg[`THRESH_DATA_LSB +: 8];
    end
    credit_return_tracker #(
      .CNT_W(CNT_W)
    ) u_tracker (
      .clk(clk),
      .sys_rst(sys_rst),
      .returnStrobe(strobe),
      .returnAmount(amount),
      .bufferFull(user_buffer_full[g]),
      .timerTick(timerTick),
      .threshold(limit),
      .updateTaken(updateFcTaken[g]),
      .pending(pendArr[g]),
      .updateRequest(updateFcRequest[g])
    );
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_first_lane: assert property (@(posedge clk) disable iff (sys_rst)
    recv_pkt_valid |-> recv_pkt_word[DATA_W-1 -: 8] == $past(linkWord[7:0]))
    else $error("first byte not in top lane");
  a_second_lane: assert property (@(posedge clk)
    disable iff (sys_rst)
    recv_pkt_valid |->
      recv_pkt_word[DATA_W-9 -: 8] == $past(linkWord[15:8]))
    else $error("second byte lane wrong");
  a_start_mark: assert property (@(posedge clk) disable iff (sys_rst)
    linkValid && linkFirst |=> recv_pkt_first && recv_pkt_valid)
    else $error("start marker missing");
  a_end_mark: assert property (@(posedge clk) disable iff (sys_rst)
    linkValid && linkLast && rxState == RX_BUSY |=> recv_pkt_last)
    else $error("end marker missing");
  a_half_word: assert property (@(posedge clk) disable iff (sys_rst)
    recv_upper_half_only |-> DATA_W == 64 && recv_pkt_valid)
    else $error("half-word flag outside wide beat");
  a_locked_flag: assert property (@(posedge clk)
    disable iff (sys_rst)
    linkValid && linkFirst && lockedRead |=>
      recv_unsupported_flag && recv_pkt_valid)
    else $error("locked read not flagged or not forwarded");
  a_malformed: assert property (@(posedge clk) disable iff (sys_rst)
    linkValid && linkFirst && linkLengthBad |=> recv_malformed_flag)
    else $error("malformed flag missing");
  a_pair_lower: assert property (@(posedge clk)
    disable iff (sys_rst)
    ctrlReg[`CTRL_PAIR_LSB] && linkValid && linkFirst && linkBarHit[1]
      |=> recv_bar_hit[0] && !recv_bar_hit[1])
    else $error("pair hit not on lower bit");
  a_bar_update: assert property (@(posedge clk)
    disable iff (sys_rst)
    !$stable(recv_bar_hit) |-> recv_pkt_first)
    else $error("match vector moved without start");
  a_full_update: assert property (@(posedge clk)
    disable iff (sys_rst)
    user_buffer_full[2] |=> updateFcRequest[2])
    else $error("buffer full did not request update");
  a_timer_update: assert property (@(posedge clk)
    disable iff (sys_rst)
    timerTick && pendArr[0] != '0 && !updateFcTaken[0] |=> ##1
      updateFcRequest[0])
    else $error("timer expiry did not request update");

  c_full_packet: cover property (@(posedge clk) disable iff (sys_rst)
    recv_pkt_first ##1 recv_pkt_valid [*2] ##1 recv_pkt_last);
  c_locked_read: cover property (@(posedge clk) disable iff (sys_rst)
    recv_unsupported_flag && recv_pkt_last);
  c_data_return: cover property (@(posedge clk) disable iff (sys_rst)
    data_credit_returned[0] ##[1:4] updateFcRequest[2]);

endmodule
`default_nettype wire

// ### user_rx_partner.sv
// User-side partner: unsupported reporting and credit return
`timescale 1ns/1ps
`default_nettype none
module user_rx_partner (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] hdrCmd,
  input wire logic [1:0] dataCmd,
  input wire logic [7:0] dataAmt,
  input wire logic recv_pkt_last,
  input wire logic recv_unsupported_flag,
  output logic user_nonposted_unsupported,
  output logic [1:0] header_credit_returned,
  output logic [1:0] data_credit_returned,
  output logic [15:0] data_credit_count
);
  logic [1:0] armed;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      user_nonposted_unsupported <= 1'b0;
      header_credit_returned <= 2'b00;
      data_credit_returned <= 2'b00;
      armed <= 2'b00;
      data_credit_count <= 16'h0000;
    end else begin
      // Answer a flagged locked read as unsupported
      user_nonposted_unsupported <= recv_pkt_last &&
        recv_unsupported_flag;
      header_credit_returned <= hdrCmd;
      armed <= dataCmd;
      data_credit_returned <= armed;
      for (int i = 0; i < 2; i++) begin
        if (dataCmd[i]) begin
          data_credit_count[8*i +: 8] <= dataAmt;
        end else if (!armed[i]) begin
          // Count bus churns outside the enable
          data_credit_count[8*i +: 8] <=
            ~data_credit_count[8*i +: 8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the receive packet interface
`timescale 1ns/1ps
`default_nettype none
`include "pcie_rx_params.svh"
module tb_top
  import pcie_rx_pkg::*;
;
  localparam int TIMER = 16;
  localparam logic [1:0] OK = `AXI_OKAY;
  localparam logic [1:0] ER = `AXI_SLVERR;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [63:0] linkWord = 64'h0000_0000_0000_0000, recv_pkt_word, eWord;
  logic linkValid = 1'b0, linkFirst = 1'b0, linkLast = 1'b0;
  logic linkUpperHalfOnly = 1'b0, linkCrcBad = 1'b0, linkLengthBad = 1'b0;
  logic [6:0] linkBarHit = 7'h00, recv_bar_hit, eBar;
  logic recv_pkt_valid, recv_pkt_first, recv_pkt_last, recv_upper_half_only;
  logic recv_e2e_crc_fail, recv_unsupported_flag, recv_malformed_flag;
  logic user_nonposted_unsupported, user_posted_unsupported = 1'b0;
  logic [3:0] user_buffer_full = 4'h0, updateFcTaken = 4'h0;
  logic [3:0] updateFcRequest, ctrlExp = 4'h0, statusExp = 4'h0;
  logic [1:0] header_credit_returned, data_credit_returned;
  logic [15:0] data_credit_count;
  logic [1:0] hdrCmd = 2'b00, dataCmd = 2'b00;
  logic [7:0] dataAmt = 8'h00;
  logic [7:0] kinds [4] = '{8'h40, 8'h01, 8'h21, 8'h80};
  logic pktOpen, unsOpen, malfOpen, eV, eF, eL, eU, eC, eN, eM;
  int n_fail = 0, checks_done = 0, cycles = 0, seed = 29;

  always #4 clk = ~clk;

  pcie_rx_tlp_interface #(.DATA_W(64), .UPDFC_CYCLES(TIMER)) dut (.*);
  user_rx_partner partner (.*);

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                     input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what,
               seen, exp);
    end
  endtask

  function automatic logic [63:0] swap(input logic [63:0] w);
    for (int i = 0; i < 8; i++) swap[63-8*i -: 8] = w[8*i +: 8];
  endfunction

  function automatic logic [6:0] barMap(input logic [6:0] r,
                                        input logic [2:0] pr);
    barMap = r;
    for (int p = 0; p < 3; p++) begin
      if (pr[p] && r[2*p+1]) begin
        barMap[2*p] = 1'b1;
        barMap[2*p+1] = 1'b0;
      end
    end
  endfunction

  // -----------
  // Stream model
  // -----------
  always @(posedge clk) begin
    logic acc;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end else if (sys_rst) begin
      {pktOpen, unsOpen, malfOpen, eV, eF, eL, eU, eC, eN, eM} = '0;
      eBar = 7'h00;
    end else begin
      chk(recv_pkt_valid, eV, "valid");
      chk(recv_pkt_first, eF, "first");
      chk(recv_pkt_last, eL, "last");
      chk(recv_upper_half_only, eU, "half");
      chk(recv_e2e_crc_fail, eC, "crc");
      chk(recv_unsupported_flag, eN, "unsup");
      chk(recv_malformed_flag, eM, "malf");
      chk(recv_bar_hit, eBar, "bar");
      if (eV) chk(recv_pkt_word, eWord, "word");
      acc = linkValid && (linkFirst || pktOpen);
      if (acc && linkFirst) begin
        unsOpen = linkWord[7:0] == 8'h01 || linkWord[7:0] == 8'h21;
        malfOpen = linkWord[7];
        eBar = barMap(linkBarHit, ctrlExp[3:1]);
      end
      if (acc && linkLengthBad) malfOpen = 1'b1;
      eV = acc;
      eF = acc && linkFirst;
      eL = acc && linkLast;
      eU = acc && linkUpperHalfOnly;
      eC = acc && linkLast && linkCrcBad && ctrlExp[0];
      eN = acc && unsOpen;
      eM = acc && malfOpen;
      eWord = swap(linkWord);
      if (acc) pktOpen = !linkLast;
      if (eM) statusExp[2] = 1'b1;
      if (eN) statusExp[3] = 1'b1;
      if (eN && eL) statusExp[0] = 1'b1;
      if (user_posted_unsupported) statusExp[1] = 1'b1;
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed, "rdata");
    chk(s_axi_rresp, er, "rresp");
    @(posedge clk);
  endtask

  task automatic send_pkt(input int beats, input logic [7:0] b0,
                          input int bad);
    logic [63:0] w;
    for (int k = 0; k < beats; k++) begin
      w = {$random(seed), $random(seed)};
      if (k == 0) w[7:0] = b0;
      linkWord <= w;
      linkValid <= 1'b1;
      linkFirst <= k == 0;
      linkLast <= k == beats - 1;
      linkUpperHalfOnly <= k == beats - 1 && w[40];
      linkCrcBad <= w[41];
      linkLengthBad <= k == bad;
      linkBarHit <= w[62:56];
      @(posedge clk);
    end
  endtask

  task automatic settle(input int i, input logic [7:0] a,
                        input logic [31:0] amt);
    int n;
    n = 0;
    while (updateFcRequest[i] !== 1'b1 && n < TIMER + 8) begin
      @(posedge clk);
      n++;
    end
    chk(updateFcRequest[i], 1'b1, "fc request");
    axi_rd(a, amt, OK);
    updateFcTaken[i] <= 1'b1;
    @(posedge clk);
    updateFcTaken[i] <= 1'b0;
    repeat (2) @(posedge clk);
    chk(updateFcRequest[i], 1'b0, "fc cleared");
    axi_rd(a, 32'h0000_0000, OK);
  endtask

  // -----------
  // Main sequence
  // -----------
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    axi_rd(`RX_CTRL_OFF, `CTRL_RESET, OK);
    axi_rd(`RX_THRESH_OFF, `THRESH_RESET, OK);
    axi_rd(8'h0C, 32'h0000_0000, ER);
    axi_wr(8'h24, 32'hFFFF_FFFF, ER);
    axi_wr(`RX_CTRL_OFF, 32'h0000_0003, OK);
    ctrlExp = 4'h3;
    axi_rd(`RX_CTRL_OFF, 32'h0000_0003, OK);
    for (int p = 0; p < 16; p++) begin
      send_pkt(1 + p / 4, kinds[p % 4], p == 4 ? 0 : (p == 13 ? 1 : 9));
    end
    linkFirst <= 1'b0;
    linkLast <= 1'b0;
    repeat (2) @(posedge clk);
    linkValid <= 1'b0;
    repeat (4) @(posedge clk);
    user_posted_unsupported <= 1'b1;
    @(posedge clk);
    user_posted_unsupported <= 1'b0;
    @(posedge clk);
    axi_rd(`RX_STATUS_OFF, {28'h000_0000, statusExp}, OK);
    axi_wr(`RX_STATUS_OFF, 32'h0000_000F, OK);
    axi_rd(`RX_STATUS_OFF, 32'h0000_0000, OK);
    hdrCmd <= 2'b01;
    repeat (8) @(posedge clk);
    hdrCmd <= 2'b00;
    repeat (3) @(posedge clk);
    settle(0, `RX_PEND_OFF, 32'h0000_0008);
    dataAmt <= 8'h20;
    dataCmd <= 2'b01;
    @(posedge clk);
    dataCmd <= 2'b00;
    repeat (4) @(posedge clk);
    settle(2, 8'h18, 32'h0000_0020);
    user_buffer_full <= 4'h2;
    repeat (2) @(posedge clk);
    chk(updateFcRequest[1], 1'b1, "full request");
    user_buffer_full <= 4'h0;
    settle(1, 8'h14, 32'h0000_0000);
    dataAmt <= 8'h05;
    dataCmd <= 2'b10;
    @(posedge clk);
    dataCmd <= 2'b00;
    repeat (4) @(posedge clk);
    settle(3, 8'h1C, 32'h0000_0005);
    test_done();
  end
endmodule
`default_nettype wire
